//--- tsc_pkg.sv
// Purpose: Shared constants and types for the three-wire serial config port.
// Assumes: Core clock of 5 ns on both ends; link pins sampled in that domain.
// Notes:   Each end imports the whole package.
`default_nettype none
package tsc_pkg;
  // Frame layout
  localparam int              ADDR_W        = 15;
  localparam int              INSTR_W       = 16;
  localparam int              BYTE_W        = 8;
  localparam int              RW_BIT        = 15;
  localparam logic [3:0]      INSTR_LAST    = 4'hf;
  localparam logic [3:0]      BYTE_LAST     = 4'h7;
  localparam logic [2:0]      BIT_TOP       = 3'h7;
  localparam logic [ADDR_W-1:0] ADDR_ONE    = 15'h0001;
  // Register file
  localparam int              REG_AW        = 8;
  localparam int              REG_NUM       = 256;
  localparam logic [ADDR_W-1:0] CFG_ADDR    = 15'h0000;
  localparam int              LSB_FIRST_BIT = 6;
  localparam logic [7:0]      REG_RST       = 8'h00;
  // Pin sampler lanes on the device end
  localparam int              PIN_CS        = 0;
  localparam int              PIN_SCLK      = 1;
  localparam int              PIN_SDIO      = 2;
  localparam logic [2:0]      PIN_INIT      = 3'h5;
  // Timing: the link clock must not exceed 40 MHz
  localparam int              CORE_PERIOD_PS  = 5000;
  localparam int              SCLK_MIN_PERIOD_PS = 25000;
  localparam int              SCLK_PERIOD_PS  = 125000;
  localparam int              SCLK_HALF_CYC   =
    (SCLK_PERIOD_PS + 2 * CORE_PERIOD_PS - 1) / (2 * CORE_PERIOD_PS);
  localparam logic [7:0]      HALF_LAST     = 8'(SCLK_HALF_CYC - 1);

  typedef enum logic [3:0] {
    D_IDLE  = 4'h1,
    D_INSTR = 4'h2,
    D_WR    = 4'h4,
    D_RD    = 4'h8
  } tsc_dev_st_t;

  typedef enum logic [3:0] {
    H_IDLE  = 4'h1,
    H_LOW   = 4'h2,
    H_HIGH  = 4'h4,
    H_TRAIL = 4'h8
  } tsc_host_st_t;
endpackage
`default_nettype wire

//--- tsc_if.sv
// Purpose: Three-wire link between serial master and config port.
// Assumes: Shared data line has a pull-up when nobody drives it.
// Notes:   Output enables are active low.
`default_nettype none
interface tsc_if;
  logic cs_n;
  logic sclk;
  logic host_sdio;
  logic host_sdio_oe_n;
  logic dev_sdio;
  logic dev_sdio_oe_n;
  logic sdio;

  // Resolved level of the shared data line
  assign sdio = !host_sdio_oe_n ? host_sdio : (!dev_sdio_oe_n ? dev_sdio : 1'b1);

  modport host (output cs_n, output sclk, output host_sdio, output host_sdio_oe_n,
                input sdio);
  modport dev  (input cs_n, input sclk, input sdio,
                output dev_sdio, output dev_sdio_oe_n);
endinterface
`default_nettype wire

//--- tsc_pin_sync.sv
// Purpose: Three-stage pin sampler with agreement filter and edge pulses.
// Assumes: Pins are asynchronous to core_clk_i.
// Notes:   A change counts once stages two and three agree.
`default_nettype none
module tsc_pin_sync #(
  parameter int           W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input  wire logic         core_clk_i,
  input  wire logic         rst_n_i,
  // Pins and filtered view
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] level_o,
  output logic      [W-1:0] rise_o,
  output logic      [W-1:0] fall_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
    logic [W-1:0] rise;
    logic [W-1:0] fall;
  } tsc_sync_t;

  tsc_sync_t q;
  tsc_sync_t d;
  logic [W-1:0] agree;

  always_comb begin
    d      = q;
    d.s1   = pin_i;
    d.s2   = q.s1;
    d.s3   = q.s2;
    agree  = ~(q.s2 ^ q.s3);
    d.lvl  = (agree & q.s3) | (~agree & q.lvl);
    d.rise = d.lvl & ~q.lvl;
    d.fall = ~d.lvl & q.lvl;
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '{s1: INIT, s2: INIT, s3: INIT, lvl: INIT, rise: '0, fall: '0};
    end else begin
      q <= d;
    end
  end

  assign level_o = q.lvl;
  assign rise_o  = q.rise;
  assign fall_o  = q.fall;
endmodule
`default_nettype wire

//--- tsc_dev.sv
// Purpose: Device end of the three-wire serial config port with its registers.
// Assumes: Link clock and chip select come from the master, sampled here.
// Notes:   Pin changes reach the logic about four core cycles late.
`default_nettype none
module tsc_dev
  import tsc_pkg::*;
(
  // Clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              rst_n_i,
  // Link
  tsc_if.dev                     bus,
  // User side
  output logic                   lsb_first_o,
  output logic                   busy_o,
  output logic                   wr_strobe_o,
  output logic      [ADDR_W-1:0] wr_addr_o,
  output logic      [BYTE_W-1:0] wr_data_o
);
  typedef struct packed {
    tsc_dev_st_t                          st;
    logic [INSTR_W-1:0]                   sh;
    logic [3:0]                           cnt;
    logic                                 rd;
    logic [ADDR_W-1:0]                    addr;
    logic [BYTE_W-1:0]                    data;
    logic                                 dout;
    logic                                 oe_n;
    logic                                 wr;
    logic [ADDR_W-1:0]                    waddr;
    logic [REG_NUM-1:0][BYTE_W-1:0]       regs;
  } tsc_dev_state_t;

  tsc_dev_state_t q;
  tsc_dev_state_t d;

  logic [2:0] lvl;
  logic [2:0] rise;
  logic [2:0] fall;
  logic       cs_hi;
  logic       sck_rise;
  logic       sck_fall;
  logic       bit_in;
  logic       lsb;

  // Chip select, link clock and data are all sampled in the core domain
  tsc_pin_sync #(
    .W    (3),
    .INIT (PIN_INIT)
  ) u_sync (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .pin_i      ({bus.sdio, bus.sclk, bus.cs_n}),
    .level_o    (lvl),
    .rise_o     (rise),
    .fall_o     (fall)
  );

  assign cs_hi    = lvl[PIN_CS];
  assign sck_rise = rise[PIN_SCLK];
  assign sck_fall = fall[PIN_SCLK];
  assign bit_in   = lvl[PIN_SDIO];
  assign lsb      = q.regs[CFG_ADDR[REG_AW-1:0]][LSB_FIRST_BIT];

  // Registers above the implemented range read as zero
  function automatic logic [BYTE_W-1:0] rd_reg(
    input logic [REG_NUM-1:0][BYTE_W-1:0] regs,
    input logic [ADDR_W-1:0]              a
  );
    logic [BYTE_W-1:0] v;
    v = REG_RST;
    if (a[ADDR_W-1:REG_AW] == '0) begin
      v = regs[a[REG_AW-1:0]];
    end
    return v;
  endfunction

  // Address generator direction follows bit order
  function automatic logic [ADDR_W-1:0] step(
    input logic [ADDR_W-1:0] a,
    input logic              up
  );
    logic [ADDR_W-1:0] v;
    v = up ? (a + ADDR_ONE) : (a - ADDR_ONE);
    return v;
  endfunction

  always_comb begin
    d    = q;
    d.wr = 1'b0;
    if (cs_hi) begin
      // Any partial operation is dropped and the line is released
      d.st   = D_IDLE;
      d.cnt  = '0;
      d.oe_n = 1'b1;
    end else begin
      unique case (q.st)
        D_IDLE: begin
          d.st  = D_INSTR;
          d.cnt = '0;
        end
        D_INSTR: begin
          if (sck_rise) begin
            // Instruction bits shift in on rising edges
            d.sh  = lsb ? {bit_in, q.sh[INSTR_W-1:1]}
                        : {q.sh[INSTR_W-2:0], bit_in};
            d.cnt = q.cnt + 4'h1;
            if (q.cnt == INSTR_LAST) begin
              d.cnt  = '0;
              d.rd   = d.sh[RW_BIT];
              d.addr = d.sh[ADDR_W-1:0];
              if (d.sh[RW_BIT]) begin
                d.data = rd_reg(q.regs, d.sh[ADDR_W-1:0]);
                d.st   = D_RD;
              end else begin
                d.st   = D_WR;
              end
            end
          end
        end
        D_WR: begin
          if (sck_rise) begin
            d.data = lsb ? {bit_in, q.data[BYTE_W-1:1]}
                         : {q.data[BYTE_W-2:0], bit_in};
            d.cnt  = q.cnt + 4'h1;
            if (q.cnt == BYTE_LAST) begin
              // Register changes on the last bit, not at end of frame
              d.cnt   = '0;
              d.wr    = 1'b1;
              d.waddr = q.addr;
              if (q.addr[ADDR_W-1:REG_AW] == '0) begin
                d.regs[q.addr[REG_AW-1:0]] = d.data;
              end
              d.addr  = step(q.addr, lsb);
            end
          end
        end
        D_RD: begin
          if (sck_fall) begin
            // Bits change on falling edges so the master samples on rising
            d.dout = lsb ? q.data[q.cnt[2:0]]
                         : q.data[BIT_TOP - q.cnt[2:0]];
            d.oe_n = 1'b0;
          end
          if (sck_rise) begin
            d.cnt = q.cnt + 4'h1;
            if (q.cnt == BYTE_LAST) begin
              d.cnt  = '0;
              d.addr = step(q.addr, lsb);
              d.data = rd_reg(q.regs, d.addr);
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '{st:    D_IDLE,
             sh:    '0,
             cnt:   '0,
             rd:    1'b0,
             addr:  '0,
             data:  '0,
             dout:  1'b0,
             oe_n:  1'b1,
             wr:    1'b0,
             waddr: '0,
             regs:  {REG_NUM{REG_RST}}};
    end else begin
      q <= d;
    end
  end

  // Link outputs
  assign bus.dev_sdio      = q.dout;
  assign bus.dev_sdio_oe_n = q.oe_n;

  // User outputs
  assign lsb_first_o = lsb;
  assign busy_o      = (q.st != D_IDLE);
  assign wr_strobe_o = q.wr;
  assign wr_addr_o   = q.waddr;
  assign wr_data_o   = q.data;
endmodule
`default_nettype wire

//--- tsc_host.sv
// Purpose: Serial master end: frames commands onto the three-wire link.
// Assumes: User knows the bit order currently set in the device.
// Notes:   Link clock is divided down from core_clk_i, well under 40 MHz.
`default_nettype none
module tsc_host
  import tsc_pkg::*;
(
  // Clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              rst_n_i,
  // Link
  tsc_if.host                    bus,
  // Command
  input  wire logic              cmd_valid_i,
  output logic                   cmd_ready_o,
  input  wire logic              cmd_read_i,
  input  wire logic [ADDR_W-1:0] cmd_addr_i,
  input  wire logic [7:0]        cmd_count_i,
  input  wire logic              lsb_first_i,
  // Data
  input  wire logic [BYTE_W-1:0] wdata_i,
  output logic                   wdata_take_o,
  output logic      [BYTE_W-1:0] rdata_o,
  output logic                   rdata_valid_o,
  output logic                   done_o
);
  typedef struct packed {
    tsc_host_st_t       st;
    logic [7:0]         div;
    logic [INSTR_W-1:0] sh;
    logic [3:0]         cnt;
    logic               instr;
    logic [7:0]         left;
    logic               rd;
    logic               lsb;
    logic [BYTE_W-1:0]  rx;
    logic               cs_n;
    logic               sclk;
    logic               dout;
    logic               oe_n;
    logic               take;
    logic               rvalid;
    logic               done;
  } tsc_host_state_t;

  tsc_host_state_t q;
  tsc_host_state_t d;
  logic            tick;
  logic            sdio_lvl;

  tsc_pin_sync #(
    .W    (1),
    .INIT (1'b1)
  ) u_sync (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .pin_i      (bus.sdio),
    .level_o    (sdio_lvl),
    .rise_o     (),
    .fall_o     ()
  );

  always_comb begin
    d        = q;
    d.take   = 1'b0;
    d.rvalid = 1'b0;
    d.done   = 1'b0;
    tick     = (q.div == HALF_LAST);
    d.div    = tick ? '0 : (q.div + 8'h01);
    unique case (q.st)
      H_IDLE: begin
        d.div = '0;
        if (cmd_valid_i) begin
          d.rd    = cmd_read_i;
          d.lsb   = lsb_first_i;
          d.left  = cmd_count_i;
          d.sh    = {cmd_read_i, cmd_addr_i};
          d.cnt   = '0;
          d.instr = 1'b1;
          d.cs_n  = 1'b0;
          d.oe_n  = 1'b0;
          d.st    = H_LOW;
        end
      end
      H_LOW: begin
        if (tick) begin
          d.sclk = 1'b1;
          d.st   = H_HIGH;
          d.rx   = q.lsb ? {sdio_lvl, q.rx[BYTE_W-1:1]} : {q.rx[BYTE_W-2:0], sdio_lvl};
        end
      end
      H_HIGH: begin
        if (tick) begin
          d.sclk = 1'b0;
          d.st   = H_LOW;
          d.cnt  = q.cnt + 4'h1;
          d.sh   = q.lsb ? (q.sh >> 1) : (q.sh << 1);
          if (q.instr && q.cnt == INSTR_LAST) begin
            d.instr = 1'b0;
            d.cnt   = '0;
            // Read hands the line over to the device
            d.oe_n  = q.rd;
            if (!q.rd) begin
              d.sh   = q.lsb ? {8'h00, wdata_i} : {wdata_i, 8'h00};
              d.take = 1'b1;
            end
          end else if (!q.instr && q.cnt == BYTE_LAST) begin
            d.cnt    = '0;
            d.rvalid = q.rd;
            if (q.left == '0) begin
              d.st = H_TRAIL;
            end else begin
              d.left = q.left - 8'h01;
              if (!q.rd) begin
                d.sh   = q.lsb ? {8'h00, wdata_i} : {wdata_i, 8'h00};
                d.take = 1'b1;
              end
            end
          end
        end
      end
      H_TRAIL: begin
        if (tick) begin
          d.cs_n = 1'b1;
          d.oe_n = 1'b1;
          d.done = 1'b1;
          d.st   = H_IDLE;
        end
      end
    endcase
    d.dout = d.lsb ? d.sh[0] : d.sh[INSTR_W-1];
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '{st: H_IDLE, div: '0, sh: '0, cnt: '0, instr: 1'b0, left: '0,
             rd: 1'b0, lsb: 1'b0, rx: '0, cs_n: 1'b1, sclk: 1'b0, dout: 1'b0,
             oe_n: 1'b1, take: 1'b0, rvalid: 1'b0, done: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign bus.cs_n           = q.cs_n;
  assign bus.sclk           = q.sclk;
  assign bus.host_sdio      = q.dout;
  assign bus.host_sdio_oe_n = q.oe_n;
  assign cmd_ready_o        = (q.st == H_IDLE);
  assign wdata_take_o       = q.take;
  assign rdata_o            = q.rx;
  assign rdata_valid_o      = q.rvalid;
  assign done_o             = q.done;
endmodule
`default_nettype wire

//--- tsc_link_properties.sv
// Purpose: Timing checks on the three-wire link between the two ends.
// Assumes: Link pins sampled on the shared core clock.
// Notes:   Rise count restarts whenever select is high.
`default_nettype none
module tsc_link_properties (
  // Clock and reset
  input  wire logic core_clk_i,
  input  wire logic rst_n_i,
  // Link
  input  wire logic cs_n,
  input  wire logic sclk,
  input  wire logic host_sdio,
  input  wire logic host_sdio_oe_n,
  input  wire logic dev_sdio,
  input  wire logic dev_sdio_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic       sclk;
    logic [7:0] rises;
    logic [3:0] since_fall;
  } tsc_chk_st_t;

  tsc_chk_st_t st_q;
  tsc_chk_st_t st_d;

  always_comb begin
    st_d      = st_q;
    st_d.sclk = sclk;
    if (cs_n) begin
      st_d.rises = 8'h00;
    end else if (sclk && !st_q.sclk) begin
      st_d.rises = st_q.rises + 8'h01;
    end
    if (!sclk && st_q.sclk) begin
      st_d.since_fall = 4'h0;
    end else if (st_q.since_fall != 4'hf) begin
      st_d.since_fall = st_q.since_fall + 4'h1;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= '{sclk: 1'b0, rises: 8'h00, since_fall: 4'hf};
    end else begin
      st_q <= st_d;
    end
  end

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  no_contention_a: assert property (!(!host_sdio_oe_n && !dev_sdio_oe_n))
    else $error("both ends drive the data line");
  dev_release_a: assert property (cs_n [*8] |-> dev_sdio_oe_n)
    else $error("device drives data line while deselected");
  clk_idle_a: assert property (cs_n |-> !sclk)
    else $error("link clock active while deselected");
  clk_rate_a: assert property ($rose(sclk) |=> (!$rose(sclk)) [*4])
    else $error("link clock period below five core cycles");
  frame_len_a: assert property ($rose(cs_n)
    |-> st_q.rises >= 8'h18 && st_q.rises[2:0] == 3'h0)
    else $error("frame is not instruction plus whole bytes");
  instr_drive_a: assert property (!cs_n && st_q.rises < 8'h10 |-> !host_sdio_oe_n)
    else $error("host not driving during instruction");
  dev_turn_a: assert property (!dev_sdio_oe_n && !cs_n |-> st_q.rises >= 8'h10)
    else $error("device drives before instruction ends");
  dev_fall_a: assert property (!dev_sdio_oe_n && !$past(dev_sdio_oe_n)
    && $changed(dev_sdio) |-> st_q.since_fall <= 4'h9)
    else $error("read bit changes away from falling clock");
  host_hold_a: assert property ($rose(sclk) && !host_sdio_oe_n
    |=> $stable(host_sdio) [*4])
    else $error("host data moves around rising clock");
endmodule
`default_nettype wire

//--- tb_three_wire_serial_config_port.sv
// Purpose: Both ends back to back; writes, reads, order switch, abort.
// Assumes: Host bit order set to match the device before each frame.
// Notes:   Inputs change on the falling edge of the core clock.
`default_nettype none
module tb_three_wire_serial_config_port
  import tsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic              core_clk_i  = 1'b0;
  logic              rst_n_i     = 1'b0;
  logic              host_rst_n  = 1'b0;
  logic              cmd_valid   = 1'b0;
  logic              cmd_read    = 1'b0;
  logic [ADDR_W-1:0] cmd_addr    = '0;
  logic [7:0]        cmd_count   = 8'h00;
  logic              lsb_first   = 1'b0;
  logic [BYTE_W-1:0] wdata       = 8'h00;
  logic              cmd_ready;
  logic              wdata_take;
  logic [BYTE_W-1:0] rdata;
  logic              rdata_valid;
  logic              done;
  logic              dev_lsb;
  logic              dev_busy;
  logic              wr_strobe;
  logic [ADDR_W-1:0] wr_addr;
  logic [BYTE_W-1:0] wr_data;
  wire logic         chk_rst_n   = rst_n_i & host_rst_n;
  int                failures    = 0;
  int                n_compared  = 0;
  int                widx        = 0;
  logic [7:0]        wq[$];
  logic [7:0]        rq[$];
  logic [7:0]        dq[$];
  logic [ADDR_W-1:0] aq[$];

  always #2.5 core_clk_i = ~core_clk_i;

  tsc_if link ();

  tsc_host tsc_host_i (
    .core_clk_i    (core_clk_i),
    .rst_n_i       (host_rst_n),
    .bus           (link),
    .cmd_valid_i   (cmd_valid),
    .cmd_ready_o   (cmd_ready),
    .cmd_read_i    (cmd_read),
    .cmd_addr_i    (cmd_addr),
    .cmd_count_i   (cmd_count),
    .lsb_first_i   (lsb_first),
    .wdata_i       (wdata),
    .wdata_take_o  (wdata_take),
    .rdata_o       (rdata),
    .rdata_valid_o (rdata_valid),
    .done_o        (done)
  );

  tsc_dev tsc_dev_i (
    .core_clk_i  (core_clk_i),
    .rst_n_i     (rst_n_i),
    .bus         (link),
    .lsb_first_o (dev_lsb),
    .busy_o      (dev_busy),
    .wr_strobe_o (wr_strobe),
    .wr_addr_o   (wr_addr),
    .wr_data_o   (wr_data)
  );

  tsc_link_properties tsc_link_properties_i (
    .core_clk_i     (core_clk_i),
    .rst_n_i        (chk_rst_n),
    .cs_n           (link.cs_n),
    .sclk           (link.sclk),
    .host_sdio      (link.host_sdio),
    .host_sdio_oe_n (link.host_sdio_oe_n),
    .dev_sdio       (link.dev_sdio),
    .dev_sdio_oe_n  (link.dev_sdio_oe_n)
  );

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("compared=%0d failures=%0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic go(input logic rd, input logic [ADDR_W-1:0] a, input int n, input logic lsb);
    @(negedge core_clk_i);
    cmd_valid = 1'b1;
    cmd_read  = rd;
    cmd_addr  = a;
    cmd_count = 8'(n - 1);
    lsb_first = lsb;
    widx      = 0;
    wdata     = (wq.size() > 0) ? wq[0] : 8'h00;
    rq        = {};
    aq        = {};
    dq        = {};
    @(negedge core_clk_i);
    cmd_valid = 1'b0;
    check({15'h0, cmd_ready}, 16'h0000);
  endtask

  // One cycle of watching both user sides
  task automatic step();
    @(negedge core_clk_i);
    if (wdata_take === 1'b1) begin
      widx++;
      wdata = (widx < wq.size()) ? wq[widx] : 8'h00;
    end
    if (rdata_valid === 1'b1) rq.push_back(rdata);
    if (wr_strobe === 1'b1) begin
      aq.push_back(wr_addr);
      dq.push_back(wr_data);
    end
  endtask

  task automatic frame(input logic rd, input logic [ADDR_W-1:0] a, input int n, input logic lsb);
    int k;
    go(rd, a, n, lsb);
    for (k = 0; k < 4000 && done !== 1'b1; k++) step();
    check({15'h0, done}, 16'h0001);
    repeat (8) @(negedge core_clk_i);
    check({15'h0, cmd_ready}, 16'h0001);
    check({15'h0, dev_busy}, 16'h0000);
  endtask

  task automatic t_reset();
    check({15'h0, link.cs_n}, 16'h0001);
    check({15'h0, link.dev_sdio_oe_n}, 16'h0001);
    check({15'h0, dev_lsb}, 16'h0000);
    wq = {};
    frame(1'b1, CFG_ADDR, 1, 1'b0);
    check(16'(rq.size()), 16'h0001);
    check({8'h0, rq[0]}, {8'h0, REG_RST});
  endtask

  task automatic t_msb();
    int i;
    wq = '{8'ha5, 8'h3c, 8'h0f};
    frame(1'b0, 15'h0002, 3, 1'b0);
    check(16'(aq.size() + rq.size()), 16'h0003);
    for (i = 0; i < 3; i++) begin
      check({1'b0, aq[i]}, 16'(2 - i));
      check({8'h0, dq[i]}, {8'h0, wq[i]});
    end
    frame(1'b1, 15'h0002, 3, 1'b0);
    check(16'(aq.size() + rq.size()), 16'h0003);
    for (i = 0; i < 3; i++) check({8'h0, rq[i]}, {8'h0, wq[i]});
  endtask

  task automatic t_lsb();
    int i;
    wq = '{8'h40};
    frame(1'b0, CFG_ADDR, 1, 1'b0);
    check({15'h0, dev_lsb}, 16'h0001);
    wq = '{8'h11, 8'h82};
    frame(1'b0, 15'h00fe, 2, 1'b1);
    for (i = 0; i < 2; i++) check({1'b0, aq[i]}, 16'(254 + i));
    frame(1'b1, 15'h00fe, 2, 1'b1);
    for (i = 0; i < 2; i++) check({8'h0, rq[i]}, {8'h0, wq[i]});
    wq = '{8'h00};
    frame(1'b0, CFG_ADDR, 1, 1'b1);
    check({15'h0, dev_lsb}, 16'h0000);
  endtask

  // Host reset mid-byte lifts select and cuts the frame short
  task automatic t_abort();
    int k;
    wq = '{8'h5a};
    go(1'b0, 15'h0005, 1, 1'b0);
    for (k = 0; k < 560; k++) step();
    check({15'h0, dev_busy}, 16'h0001);
    host_rst_n = 1'b0;
    repeat (4) step();
    host_rst_n = 1'b1;
    repeat (8) step();
    check(16'(aq.size()), 16'h0000);
    check({15'h0, dev_busy}, 16'h0000);
    wq = '{8'hc3};
    frame(1'b0, 15'h0005, 1, 1'b0);
    check({1'b0, aq[0]}, 16'h0005);
    check({8'h0, dq[0]}, 16'h00c3);
  endtask

  initial begin
    repeat (16) @(negedge core_clk_i);
    rst_n_i    = 1'b1;
    host_rst_n = 1'b1;
    repeat (4) @(negedge core_clk_i);
    t_reset();
    t_msb();
    t_lsb();
    t_abort();
    print_verdict();
  end

  // About ten frames of some 1100 cycles each fit well inside this span
  initial begin
    #400us;
    failures++;
    print_verdict();
  end
endmodule
`default_nettype wire
